// file: tbcc_pkg.sv
`default_nettype none
package tbcc_pkg;
   // Register byte offsets
   localparam logic [7:0] TBCC_OFF_CCEN = 8'h20;
   localparam logic [7:0] TBCC_OFF_CNT = 8'h24;
   localparam logic [7:0] TBCC_OFF_PSC = 8'h28;
   localparam logic [7:0] TBCC_OFF_RLD = 8'h2C;
   localparam logic [7:0] TBCC_OFF_REP = 8'h30;
   // Reset values
   localparam logic [15:0] TBCC_RST_CCEN = 16'h0000;
   localparam logic [15:0] TBCC_RST_CNT = 16'h0000;
   localparam logic [15:0] TBCC_RST_PSC = 16'h0000;
   localparam logic [15:0] TBCC_RST_RLD = 16'hFFFF;
   localparam logic [7:0] TBCC_RST_REP = 8'h00;
   // Channel enable and polarity field layout
   localparam int TBCC_CH_STRIDE = 4;
   localparam int TBCC_BIT_EN = 0;
   localparam int TBCC_BIT_POL = 1;
   localparam int TBCC_BIT_CEN = 2;
   localparam int TBCC_BIT_CPOL = 3;
   localparam int TBCC_NUM_CH = 4;
   localparam int TBCC_NUM_COMP = 3;
   localparam logic [15:0] TBCC_CCEN_USED = 16'h3FFF;
   localparam logic [15:0] TBCC_CCEN_POL = 16'h2AAA;
   localparam logic [1:0] TBCC_PROT_LOCK = 2'h2;
   localparam logic [15:0] TBCC_CNT_STEP = 16'h0001;
   localparam logic [7:0] TBCC_REP_STEP = 8'h01;

   // APB request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } tbcc_apb_req_s;

   // APB answer to the master
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } tbcc_apb_rsp_s;

   // One channel's enable and polarity bits
   typedef struct packed {
      logic comp_polarity;
      logic comp_enable;
      logic polarity;
      logic enable;
   } tbcc_ch_cfg_s;
endpackage : tbcc_pkg
`default_nettype wire

// file: tbcc_prescaler.sv
`default_nettype none
module tbcc_prescaler (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [15:0] i_prescale_value,
   output logic o_tick
);
   import tbcc_pkg::*;

   typedef struct packed {
      logic [15:0] div;
   } tbcc_psc_st_s;

   tbcc_psc_st_s st;
   tbcc_psc_st_s next_st;

   // One tick every prescale_value plus one clocks
   assign o_tick = (st.div == i_prescale_value);

   // Divider wraps on the tick; a smaller new value wraps at once
   always_comb begin
      next_st = st;
      if (st.div >= i_prescale_value) begin
         next_st.div = '0;
      end else begin
         next_st.div = st.div + TBCC_CNT_STEP;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule : tbcc_prescaler
`default_nettype wire

// file: tbcc_channel.sv
`default_nettype none
module tbcc_channel #(
   parameter bit HAS_COMP = 1'b1
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire tbcc_pkg::tbcc_ch_cfg_s i_cfg,
   input wire logic i_dir_input,
   input wire logic i_input_signal,
   input wire logic [15:0] i_count,
   input wire logic [15:0] i_cmp_value,
   input wire logic i_preload_en,
   input wire logic i_update,
   output logic o_main,
   output logic o_comp,
   output logic [15:0] o_capture,
   output logic o_capture_strobe
);
   import tbcc_pkg::*;

   typedef struct packed {
      logic [15:0] cmp_act;
      logic prev_in;
      logic main;
      logic comp;
      logic [15:0] cap;
      logic cap_stb;
   } tbcc_ch_st_s;

   tbcc_ch_st_s st;
   tbcc_ch_st_s next_st;
   logic [15:0] cmp_eff;
   logic ref_lvl;
   logic sig;

   assign o_main = st.main;
   assign o_comp = st.comp;
   assign o_capture = st.cap;
   assign o_capture_strobe = st.cap_stb;

   // Without preload a new compare value acts at once
   assign cmp_eff = i_preload_en ? st.cmp_act : i_cmp_value;
   assign ref_lvl = (i_count < cmp_eff);
   assign sig = i_input_signal ^ i_cfg.polarity;

   // Output shaping and capture
   always_comb begin
      next_st = st;
      next_st.cap_stb = 1'b0;
      next_st.prev_in = sig;
      if (!i_preload_en || i_update) begin
         next_st.cmp_act = i_cmp_value;
      end
      if (i_dir_input) begin
         next_st.main = 1'b0;
         next_st.comp = 1'b0;
         // Rising edge of the chosen phase, only when enabled
         if (i_cfg.enable && sig && !st.prev_in) begin
            next_st.cap = i_count;
            next_st.cap_stb = 1'b1;
         end
      end else begin
         next_st.main = i_cfg.enable & (ref_lvl ^ i_cfg.polarity);
         next_st.comp = HAS_COMP & i_cfg.comp_enable
                        & (~ref_lvl ^ i_cfg.comp_polarity);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   AST_OUT_OFF: assert property (
      !i_dir_input && !i_cfg.enable |=> !o_main)
      else $error("disabled output is driven active");
   AST_CAP_BLOCK: assert property (
      !i_cfg.enable |=> !o_capture_strobe)
      else $error("capture taken while channel disabled");
   AST_CMP_HOLD: assert property (
      i_preload_en && !i_update |=> $stable(st.cmp_act))
      else $error("preloaded compare value changed before update");
endmodule : tbcc_channel
`default_nettype wire

// file: tbcc_timebase.sv
// Design decision made here: the APB slave port.
`default_nettype none
// Notes on behaviour
// - For an output channel the enable bit gates the main output.
// - For an input channel the enable bit decides whether capture occurs.
// - For an output channel polarity 0 means high active, 1 low active.
// - For an input channel polarity 1 inverts the trigger and capture input.
// - Polarity bit writes are ignored at protection level 2 or 3.
// - Bit 2 enables the channel 1 complementary output.
// - Bit 3 makes the complementary output low active when set.
// - Channels 2 and 3 repeat the nibble, channel 4 has bits 12-13 only.
// - The counter advances once every prescale value plus one clocks.
// - The counter holds while the reload value is zero; it resets to FFFF.
// - The repeat count drops per period and at zero makes an update.
// - A new repeat value is loaded only at the next update event.
// - The counter value is a 16-bit read-write register reset to zero.
// - With preload a compare value acts at update, otherwise at once.
module tbcc_timebase (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire tbcc_pkg::tbcc_apb_req_s i_apb,
   output tbcc_pkg::tbcc_apb_rsp_s o_apb,
   input wire logic [1:0] i_protect_level,
   input wire logic [3:0] i_ch_dir_input,
   input wire logic [3:0] i_ch_input_signal,
   input wire logic [3:0][15:0] i_cmp_value,
   input wire logic [3:0] i_cmp_preload_en,
   output logic [3:0] o_ch_main_output,
   output logic [2:0] o_ch_comp_output,
   output logic [3:0][15:0] o_capture_value,
   output logic [3:0] o_capture_strobe,
   output logic o_update_event,
   output logic [15:0] o_counter_value
);
   import tbcc_pkg::*;

   typedef struct packed {
      logic [15:0] ccen;
      logic [15:0] cnt;
      logic [15:0] prescale_value;
      logic [15:0] psc_act;
      logic [15:0] rld;
      logic [7:0] rep;
      logic [7:0] rep_act;
      logic upd;
      tbcc_apb_rsp_s rsp;
   } tbcc_top_st_s;

   tbcc_top_st_s st;
   tbcc_top_st_s next_st;
   logic tick;
   logic period;
   logic upd_now;
   logic access;
   logic wr;
   logic hit;
   logic [15:0] rd_val;
   logic [15:0] pol_keep;
   logic [3:0] comp_w;

   assign o_apb = st.rsp;
   assign o_update_event = st.upd;
   assign o_counter_value = st.cnt;
   assign o_ch_comp_output = comp_w[TBCC_NUM_COMP-1:0];

   // Prescaler runs from the shadow value so a period ends at the old rate
   tbcc_prescaler u_prescaler (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_prescale_value(st.psc_act),
      .o_tick(tick)
   );

   // One channel per nibble; channel 4 has no complementary pair
   for (genvar i = 0; i < TBCC_NUM_CH; i++) begin : g_ch
      tbcc_channel #(
         .HAS_COMP(i < TBCC_NUM_COMP)
      ) u_ch (
         .i_clk(i_clk),
         .i_sys_rst(i_sys_rst),
         .i_cfg(st.ccen[i*TBCC_CH_STRIDE +: TBCC_CH_STRIDE]),
         .i_dir_input(i_ch_dir_input[i]),
         .i_input_signal(i_ch_input_signal[i]),
         .i_count(st.cnt),
         .i_cmp_value(i_cmp_value[i]),
         .i_preload_en(i_cmp_preload_en[i]),
         .i_update(st.upd),
         .o_main(o_ch_main_output[i]),
         .o_comp(comp_w[i]),
         .o_capture(o_capture_value[i]),
         .o_capture_strobe(o_capture_strobe[i])
      );
   end

   // APB handshake: one wait state, write lands at the pready edge
   assign access = i_apb.psel & i_apb.penable;
   assign wr = access & st.rsp.pready & i_apb.pwrite;

   // Counter period and update detection
   always_comb begin
      period = 1'b0;
      if (tick && st.rld != '0 && st.cnt >= st.rld) begin
         period = 1'b1;
      end
      upd_now = period && (st.rep_act == '0);
   end

   // Polarity bits stay put while the protection level locks them
   always_comb begin
      if (i_protect_level >= TBCC_PROT_LOCK) begin
         pol_keep = TBCC_CCEN_POL;
      end else begin
         pol_keep = '0;
      end
   end

   // Read multiplexer and address decode
   always_comb begin
      hit = 1'b1;
      rd_val = '0;
      if (i_apb.paddr == TBCC_OFF_CCEN) begin
         rd_val = st.ccen;
      end else if (i_apb.paddr == TBCC_OFF_CNT) begin
         rd_val = st.cnt;
      end else if (i_apb.paddr == TBCC_OFF_PSC) begin
         rd_val = st.prescale_value;
      end else if (i_apb.paddr == TBCC_OFF_RLD) begin
         rd_val = st.rld;
      end else if (i_apb.paddr == TBCC_OFF_REP) begin
         rd_val = {8'h00, st.rep};
      end else begin
         hit = 1'b0;
      end
   end

   // Next state of counter, repetition, shadows and bus answer
   always_comb begin
      next_st = st;
      next_st.upd = upd_now;
      // Zero reload stops counting; a software write can still set the count
      if (tick && st.rld != '0) begin
         if (period) begin
            next_st.cnt = '0;
         end else begin
            next_st.cnt = st.cnt + TBCC_CNT_STEP;
         end
      end
      if (period) begin
         if (upd_now) begin
            next_st.rep_act = st.rep;
            next_st.psc_act = st.prescale_value;
         end else begin
            next_st.rep_act = st.rep_act - TBCC_REP_STEP;
         end
      end
      // Answer is registered so pready comes from a flop
      next_st.rsp.pready = access & ~st.rsp.pready;
      next_st.rsp.pslverr = access & ~st.rsp.pready & ~hit;
      if (access && !st.rsp.pready && !i_apb.pwrite) begin
         next_st.rsp.prdata = {16'h0000, rd_val};
      end else if (!access) begin
         next_st.rsp.prdata = '0;
      end
      // Software writes win over counting in the same cycle
      if (wr) begin
         if (i_apb.paddr == TBCC_OFF_CCEN) begin
            next_st.ccen = ((i_apb.pwdata[15:0] & ~pol_keep)
                            | (st.ccen & pol_keep)) & TBCC_CCEN_USED;
         end else if (i_apb.paddr == TBCC_OFF_CNT) begin
            next_st.cnt = i_apb.pwdata[15:0];
         end else if (i_apb.paddr == TBCC_OFF_PSC) begin
            next_st.prescale_value = i_apb.pwdata[15:0];
         end else if (i_apb.paddr == TBCC_OFF_RLD) begin
            next_st.rld = i_apb.pwdata[15:0];
         end else if (i_apb.paddr == TBCC_OFF_REP) begin
            next_st.rep = i_apb.pwdata[7:0];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st.ccen <= TBCC_RST_CCEN;
         st.cnt <= TBCC_RST_CNT;
         st.prescale_value <= TBCC_RST_PSC;
         st.psc_act <= TBCC_RST_PSC;
         st.rld <= TBCC_RST_RLD;
         st.rep <= TBCC_RST_REP;
         st.rep_act <= TBCC_RST_REP;
         st.upd <= 1'b0;
         st.rsp <= '0;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   AST_HOLD_ZERO: assert property (
      st.rld == '0 && !wr |=> $stable(st.cnt))
      else $error("counter moved with zero reload");
   AST_STEP_ON_TICK: assert property (
      !tick && !wr |=> $stable(st.cnt))
      else $error("counter moved without prescaler tick");
   AST_WRAP: assert property (
      period && !wr |=> st.cnt == '0)
      else $error("counter did not wrap to zero");
   AST_UPDATE: assert property (
      period && st.rep_act == '0 |=> o_update_event)
      else $error("no update event at repeat zero");
   AST_REP_DEC: assert property (
      period && st.rep_act != '0 |=>
      st.rep_act == $past(st.rep_act) - TBCC_REP_STEP && !o_update_event)
      else $error("repeat count did not step down");
   AST_REP_LATE: assert property (
      !upd_now && !period |=> $stable(st.rep_act))
      else $error("repeat count changed outside update");
   AST_PSC_LATE: assert property (
      !upd_now |=> $stable(st.psc_act))
      else $error("prescaler applied before update");
   AST_POL_LOCK: assert property (
      wr && i_apb.paddr == TBCC_OFF_CCEN && i_protect_level >= TBCC_PROT_LOCK
      |=> (st.ccen & TBCC_CCEN_POL) == ($past(st.ccen) & TBCC_CCEN_POL))
      else $error("polarity bit changed while locked");
   AST_RESERVED: assert property (
      (st.ccen & ~TBCC_CCEN_USED) == '0)
      else $error("reserved enable bits set");
endmodule : tbcc_timebase
`default_nettype wire

// file: tbcc_fix_note.sv
`default_nettype none
`default_nettype wire

// file: tbcc_timebase_tb.sv
`default_nettype none
module tbcc_timebase_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import tbcc_pkg::*;
   typedef struct packed {logic rd; logic err; logic [31:0] data;} tbcc_note_s;
   logic i_clk;
   logic i_sys_rst;
   tbcc_apb_req_s apb_req;
   tbcc_apb_rsp_s apb_rsp;
   logic [1:0] prot;
   logic [3:0] dir, insig, pre_en, main_o, cap_stb;
   logic [3:0][15:0] cmp, cap;
   logic [2:0] comp_o;
   logic upd;
   logic [15:0] cnt;
   int num_errors, total_checks, cyc_n;
   tbcc_note_s apb_q[$];
   tbcc_note_s note;
   logic [15:0] cap_q[$];
   int upd_t[$];

   tbcc_timebase tbcc_timebase_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_apb(apb_req), .o_apb(apb_rsp), .i_protect_level(prot),
      .i_ch_dir_input(dir), .i_ch_input_signal(insig), .i_cmp_value(cmp),
      .i_cmp_preload_en(pre_en), .o_ch_main_output(main_o),
      .o_ch_comp_output(comp_o), .o_capture_value(cap),
      .o_capture_strobe(cap_stb), .o_update_event(upd),
      .o_counter_value(cnt));

   // Free-running clock at 40 MHz
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic results();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   // Results are matched against notes in arrival order, so an answer
   // nobody asked for shows up as a mismatch too
   always @(posedge i_clk) begin
      cyc_n++;
      if (upd === 1'b1) upd_t.push_back(cyc_n);
      if (apb_rsp.pready === 1'b1) begin
         if (apb_q.size() == 0) begin
            check("apb answer", 32'h0, 32'h1);
         end else begin
            note = apb_q.pop_front();
            check("pslverr", {31'h0, note.err}, {31'h0, apb_rsp.pslverr});
            if (note.rd) check("prdata", note.data, apb_rsp.prdata);
         end
      end
      if (cap_stb[0] === 1'b1) begin
         if (cap_q.size() == 0) check("capture strobe", 32'h0, 32'h1);
         else check("capture value", {16'h0, cap_q.pop_front()}, {16'h0, cap[0]});
      end
   end

   // One APB transfer; pready is sampled at the rising edge while the
   // request still stands, and an idle edge follows the release
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] exp,
                      input logic err);
      int w;
      apb_q.push_back('{rd: !wr, err: err, data: exp});
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite <= wr;
      apb_req.paddr <= a;
      apb_req.pwdata <= d;
      @(posedge i_clk);
      apb_req.penable <= 1'b1;
      w = 0;
      do begin
         @(posedge i_clk);
         w++;
      end while (apb_rsp.pready !== 1'b1 && w < 50);
      if (w >= 50) check("apb timeout", 32'h0, 32'h1);
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      @(posedge i_clk);
   endtask : apb

   task automatic wait_upd();
      int n0;
      int w;
      n0 = upd_t.size();
      w = 0;
      while (upd_t.size() == n0 && w < 500) begin
         @(posedge i_clk);
         w++;
      end
      if (w >= 500) check("update timeout", 32'h0, 32'h1);
   endtask : wait_upd

   // Watchdog sized well above the whole sequence
   initial begin
      repeat (20000) @(posedge i_clk);
      num_errors++;
      results();
   end

   initial begin
      logic [7:0] r_off [4];
      logic [15:0] r_val [4];
      logic [15:0] v;
      logic [3:0] em;
      logic [2:0] ec;
      logic rf;
      r_off = '{TBCC_OFF_CCEN, TBCC_OFF_PSC, TBCC_OFF_RLD, TBCC_OFF_REP};
      r_val = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0000};
      i_sys_rst = 1'b1;
      apb_req = '0;
      prot = 2'h0;
      dir = 4'h0;
      insig = 4'h0;
      pre_en = 4'h0;
      cmp = '0;
      void'($urandom(32'h77682A11));
      repeat (5) @(posedge i_clk);
      @(negedge i_clk);
      check("counter in reset", 32'h0, {16'h0, cnt});
      @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      // Reset values, then the unmapped word after the table
      for (int i = 0; i < 4; i++) apb(0, r_off[i], 0, {16'h0, r_val[i]}, 0);
      apb(0, 8'h34, 0, 32'h0, 1);
      apb(1, 8'h34, 32'hFFFF, 32'h0, 1);
      apb(1, TBCC_OFF_CCEN, 32'hFFFFFFFF, 0, 0);
      apb(0, TBCC_OFF_CCEN, 0, 32'h3FFF, 0);
      apb(1, TBCC_OFF_REP, 32'h1FF, 0, 0);
      apb(0, TBCC_OFF_REP, 0, 32'hFF, 0);
      // Polarity bits survive a clearing write at levels 2 and 3
      for (int l = 0; l < 4; l++) begin
         prot <= 2'h0;
         apb(1, TBCC_OFF_CCEN, 32'h3FFF, 0, 0);
         prot <= l[1:0];
         apb(1, TBCC_OFF_CCEN, 32'h0, 0, 0);
         apb(0, TBCC_OFF_CCEN, 0, (l >= 2) ? 32'h2AAA : 32'h0, 0);
      end
      prot <= 2'h0;
      // Zero reload freezes the counter at what software wrote
      apb(1, TBCC_OFF_RLD, 32'h0, 0, 0);
      apb(1, TBCC_OFF_CNT, 32'h5, 0, 0);
      repeat (20) @(posedge i_clk);
      check("frozen counter", 32'h5, {16'h0, cnt});
      apb(0, TBCC_OFF_CNT, 0, 32'h5, 0);
      // Random enable/polarity sets against a frozen count of 5
      for (int k = 0; k < 12; k++) begin
         v = 16'($urandom()) & 16'h3FFF;
         for (int c = 0; c < 4; c++) cmp[c] <= 16'($urandom_range(0, 10));
         insig <= 4'($urandom());
         apb(1, TBCC_OFF_CCEN, {16'h0, v}, 0, 0);
         repeat (3) @(posedge i_clk);
         for (int c = 0; c < 4; c++) begin
            rf = (16'h5 < cmp[c]);
            em[c] = v[4*c] & (rf ^ v[4*c+1]);
            if (c < 3) ec[c] = v[4*c+2] & (~rf ^ v[4*c+3]);
         end
         check("main outputs", {28'h0, em}, {28'h0, main_o});
         check("comp outputs", {29'h0, ec}, {29'h0, comp_o});
      end
      // Preloaded compare waits for an update; direct compare acts at once
      apb(1, TBCC_OFF_CCEN, 32'h1, 0, 0);
      cmp[0] <= 16'hA;
      repeat (3) @(posedge i_clk);
      pre_en[0] <= 1'b1;
      repeat (2) @(posedge i_clk);
      cmp[0] <= 16'h0;
      repeat (3) @(posedge i_clk);
      check("preloaded compare", 32'h1, {31'h0, main_o[0]});
      pre_en[0] <= 1'b0;
      repeat (3) @(posedge i_clk);
      check("direct compare", 32'h0, {31'h0, main_o[0]});
      // Channel 1 as input: every enable and polarity combination
      dir <= 4'h1;
      apb(1, TBCC_OFF_CNT, 32'h1234, 0, 0);
      for (int m = 0; m < 4; m++) begin
         apb(1, TBCC_OFF_CCEN, 32'h0, 0, 0);
         insig[0] <= m[1];
         repeat (2) @(posedge i_clk);
         apb(1, TBCC_OFF_CCEN, {30'h0, m[1:0]}, 0, 0);
         repeat (2) @(posedge i_clk);
         if (m[0]) cap_q.push_back(16'h1234);
         insig[0] <= ~m[1];
         repeat (4) @(posedge i_clk);
         insig[0] <= m[1];
         repeat (4) @(posedge i_clk);
      end
      check("captures pending", 32'h0, cap_q.size());
      // Period spacing, and late pickup of new repeat and divider values
      dir <= 4'h0;
      apb(1, TBCC_OFF_CCEN, 32'h0, 0, 0);
      apb(1, TBCC_OFF_PSC, 32'h2, 0, 0);
      apb(1, TBCC_OFF_REP, 32'h0, 0, 0);
      apb(1, TBCC_OFF_CNT, 32'h0, 0, 0);
      apb(1, TBCC_OFF_RLD, 32'h4, 0, 0);
      wait_upd();
      wait_upd();
      wait_upd();
      check("update spacing", 32'd15, upd_t[$] - upd_t[$-1]);
      apb(1, TBCC_OFF_REP, 32'h2, 0, 0);
      apb(1, TBCC_OFF_PSC, 32'h1, 0, 0);
      wait_upd();
      check("update spacing", 32'd15, upd_t[$] - upd_t[$-1]);
      wait_upd();
      check("update spacing", 32'd30, upd_t[$] - upd_t[$-1]);
      wait_upd();
      check("update spacing", 32'd30, upd_t[$] - upd_t[$-1]);
      repeat (4) @(posedge i_clk);
      check("apb pending", 32'h0, apb_q.size());
      results();
   end
endmodule : tbcc_timebase_tb
`default_nettype wire
